//--- event_channel_flags_defines.vh
/*
 * Constants for the event channel flag block: register indices, field
 * positions and reset values.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef EVENT_CHANNEL_FLAGS_DEFINES_VH
`define EVENT_CHANNEL_FLAGS_DEFINES_VH

`define ECF_NUM_CHANNELS      32
`define ECF_CH_IDX_W          5
// Printed register indices; byte address is four times the index
`define ECF_FLAG_BASE_IDX     8'h26
`define ECF_FLAG_STRIDE_IDX   8'h08
`define ECF_FLAG_RESET        8'h00
// Own registers, beyond the last channel flag index
`define ECF_IRQ_STATUS_IDX    9'h1_30
`define ECF_IRQ_MASK_IDX      9'h1_31
`define ECF_EVD_ENABLE_IDX    9'h1_32
`define ECF_OVR_ENABLE_IDX    9'h1_33
`define ECF_ASYNC_PATH_IDX    9'h1_34
// Field positions in the channel flag register
`define ECF_BIT_OVR           0
`define ECF_BIT_EVD           1
// Status bits of the summary interrupt status register
`define ECF_ST_EVD_IRQ        0
`define ECF_ST_OVR_IRQ        1
`define ECF_ADDR_W            11
`define ECF_RDATA_UNMAPPED    32'h0000_0000

`endif

//--- event_channel_slice.v
/*
 * One event channel: tracks users still handling an event, and holds the
 * event-detected and overrun flags with write-one-to-clear.
 * Assumes events and user ready/done strobes synchronous to clock_i.
 */
`timescale 1ns/1ns
`include "event_channel_flags_defines.vh"

module event_channel_slice (
    input  wire       clock_i,
    input  wire       rst_n_i,
    input  wire       event_i,
    input  wire       users_ready_i,
    input  wire       users_done_i,
    input  wire       async_path_i,
    input  wire       clr_evd_i,
    input  wire       clr_ovr_i,
    output wire [7:0] flags_o
);
    reg evd_q;
    reg ovr_q;
    reg pending_q;
    wire overrun;

    // New event while users busy or previous event unhandled
    assign overrun = event_i & (~users_ready_i | (pending_q & ~users_done_i));

    // Pending tracks an event not yet handled by every user
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_q <= 1'b0;
        end else if (event_i) begin
            pending_q <= ~async_path_i;
        end else if (users_done_i) begin
            pending_q <= 1'b0;
        end
    end

    // Set beats clear; asynchronous path never sets a flag
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evd_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            if (event_i && !async_path_i) begin
                evd_q <= 1'b1;
            end else if (clr_evd_i) begin
                evd_q <= 1'b0;
            end
            if (overrun && !async_path_i) begin
                ovr_q <= 1'b1;
            end else if (clr_ovr_i) begin
                ovr_q <= 1'b0;
            end
        end
    end

    assign flags_o = {6'h00, evd_q, ovr_q};
endmodule

//--- event_channel_flags.v
/*
 * Event channel flag block: 32 channel flag registers, per-channel
 * interrupt enables, asynchronous path selects and a summary interrupt,
 * reached over an Avalon-MM slave with waitrequest (word addresses).
 * Assumes one clock; all channel-side strobes synchronous to clock_i.
 */
`timescale 1ns/1ns
`include "event_channel_flags_defines.vh"

module event_channel_flags (
    input  wire        clock_i,
    input  wire        rst_n_i,
    // Avalon-MM slave, word address
    input  wire [10:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Channel side
    input  wire [31:0] chan_event_i,
    input  wire [31:0] chan_users_ready_i,
    input  wire [31:0] chan_users_done_i,
    // Interrupts
    output wire [31:0] chan_irq_o,
    output wire        irq_o
);
    localparam NCH = `ECF_NUM_CHANNELS;

    reg  [31:0] evd_en_q;
    reg  [31:0] ovr_en_q;
    reg  [31:0] async_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_mask_q;
    reg         ack_q;
    wire [7:0]  flags [0:NCH-1];
    wire [31:0] evd_vec;
    wire [31:0] ovr_vec;
    wire        req_valid;
    wire        wr_take;
    wire        rd_take;
    wire [7:0]  lane0_wr;
    wire [31:0] flag_hit;
    wire        wr_status;
    reg  [1:0]  st_set;
    reg  [1:0]  st_clr;
    reg  [1:0]  irq_status_d;
    reg  [31:0] rdata_d;
    integer     i;

    // Flag register index of a channel, used by decode and readback
    // Integer argument so a genvar can be passed without a part-select
    function [10:0] flag_index;
        input integer ch;
        begin
            flag_index = {3'b000, `ECF_FLAG_BASE_IDX}
                       + {3'b000, `ECF_FLAG_STRIDE_IDX} * {6'h00, ch[4:0]};
        end
    endfunction

    // True when a word address hits a given own register
    function is_own;
        input [10:0] addr;
        input [8:0]  idx;
        begin
            is_own = (addr == {2'b00, idx});
        end
    endfunction

    // One wait state: answer lands the cycle after the request is seen
    assign req_valid       = avs_read | avs_write;
    assign avs_waitrequest = req_valid & ~ack_q;
    assign wr_take         = avs_write & ack_q;
    assign rd_take         = avs_read & ~ack_q;
    assign lane0_wr        = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_valid & ~ack_q;
        end
    end

    // Per-channel flag slices with write-one-to-clear strobes
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire hit;
            // Address match shared by the clear strobes and the readback mux
            assign flag_hit[g] = (avs_address == flag_index(g));
            assign hit         = wr_take & flag_hit[g];
            event_channel_slice u_slice (
                .clock_i       (clock_i),
                .rst_n_i       (rst_n_i),
                .event_i       (chan_event_i[g]),
                .users_ready_i (chan_users_ready_i[g]),
                .users_done_i  (chan_users_done_i[g]),
                .async_path_i  (async_q[g]),
                .clr_evd_i     (hit & lane0_wr[`ECF_BIT_EVD]),
                .clr_ovr_i     (hit & lane0_wr[`ECF_BIT_OVR]),
                .flags_o       (flags[g])
            );
            assign evd_vec[g] = flags[g][`ECF_BIT_EVD];
            assign ovr_vec[g] = flags[g][`ECF_BIT_OVR];
        end
    endgenerate

    // Per-channel request from flag and its enable
    assign chan_irq_o = (evd_vec & evd_en_q) | (ovr_vec & ovr_en_q);

    // Control registers written by software
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evd_en_q   <= 32'h0000_0000;
            ovr_en_q   <= 32'h0000_0000;
            async_q    <= 32'h0000_0000;
            irq_mask_q <= 2'b00;
        end else if (wr_take) begin
            if (is_own(avs_address, `ECF_EVD_ENABLE_IDX)) begin
                evd_en_q <= avs_writedata;
            end
            if (is_own(avs_address, `ECF_OVR_ENABLE_IDX)) begin
                ovr_en_q <= avs_writedata;
            end
            if (is_own(avs_address, `ECF_ASYNC_PATH_IDX)) begin
                async_q <= avs_writedata;
            end
            if (is_own(avs_address, `ECF_IRQ_MASK_IDX)) begin
                irq_mask_q <= avs_writedata[1:0];
            end
        end
    end

    assign wr_status = wr_take & is_own(avs_address, `ECF_IRQ_STATUS_IDX);

    // Sticky summary status: any enabled request sets, write one clears, set wins
    always @* begin
        st_set       = {|(ovr_vec & ovr_en_q), |(evd_vec & evd_en_q)};
        st_clr       = wr_status ? avs_writedata[1:0] : 2'b00;
        irq_status_d = st_set | (irq_status_q & ~st_clr);
    end

    // Status register; next value settled above keeps this process plain
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_q <= 2'b00;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    assign irq_o = |(irq_status_q & irq_mask_q);

    // Readback mux; flag words are zero-extended, unmapped places read zero
    always @* begin
        rdata_d = `ECF_RDATA_UNMAPPED;
        for (i = 0; i < NCH; i = i + 1) begin
            if (flag_hit[i]) begin
                rdata_d = {24'h00_0000, flags[i]};
            end
        end
        if (is_own(avs_address, `ECF_IRQ_STATUS_IDX)) begin
            rdata_d = {30'h0000_0000, irq_status_q};
        end
        if (is_own(avs_address, `ECF_IRQ_MASK_IDX)) begin
            rdata_d = {30'h0000_0000, irq_mask_q};
        end
        if (is_own(avs_address, `ECF_EVD_ENABLE_IDX)) begin
            rdata_d = evd_en_q;
        end
        if (is_own(avs_address, `ECF_OVR_ENABLE_IDX)) begin
            rdata_d = ovr_en_q;
        end
        if (is_own(avs_address, `ECF_ASYNC_PATH_IDX)) begin
            rdata_d = async_q;
        end
    end

    // Read data registered on the wait cycle, valid when waitrequest drops
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= rdata_d;
        end
    end
endmodule

//--- event_channel_flags_chk.sv
/* Checker of the event channel flag block: bus handshake, readback and interrupt outputs.
   Sees only the top-level ports; bound to every instance at the foot. */
`timescale 1ns/1ns
module event_channel_flags_chk (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire [10:0] avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [31:0] chan_event_i,
    input wire [31:0] chan_users_ready_i,
    input wire [31:0] chan_users_done_i,
    input wire [31:0] chan_irq_o,
    input wire        irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Request still waiting, then answered
    sequence s_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ack; (avs_read || avs_write) && !avs_waitrequest; endsequence
    // Answered reads of an unmapped place and of a flag register
    sequence s_rd_hole; s_ack ##0 avs_read && avs_address > 11'h134; endsequence
    sequence s_rd_flag;
        s_ack ##0 avs_read && avs_address[2:0] == 3'h6 && avs_address <= 11'h11e;
    endsequence
    a_one_wait: assert property (s_wait |=> s_ack)
        else $error("request not answered after one wait");
    a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without a request");
    a_hole_zero: assert property (s_rd_hole |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_flag_width: assert property (s_rd_flag |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("flag register upper bits not zero");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    a_irq_cause: assert property (
        (chan_irq_o & ~$past(chan_irq_o)) != 32'h0 |-> $past(chan_event_i) != 32'h0 || $past(avs_write))
        else $error("channel request rose without event or write");
    a_irq_drop: assert property (
        (~chan_irq_o & $past(chan_irq_o)) != 32'h0 |-> $past(avs_write))
        else $error("channel request fell without a write");
    a_sum_drop: assert property ($fell(irq_o) |-> $past(avs_write))
        else $error("summary interrupt fell without a write");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && chan_irq_o == 32'h0)
        else $error("interrupts high at reset release");
endmodule
bind event_channel_flags event_channel_flags_chk event_channel_flags_chk_i (.clock_i, .rst_n_i,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .chan_event_i, .chan_users_ready_i, .chan_users_done_i, .chan_irq_o, .irq_o);

//--- event_users_model.sv
/* Model of the event generators and users on the channel side.
   The bench commands fire, busy and hold; event and done follow clock_i, ready follows busy directly. */
`timescale 1ns/1ns
module event_users_model (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire [31:0] fire_i,
    input  wire [31:0] busy_i,
    input  wire [31:0] hold_i,
    output reg  [31:0] event_o,
    output wire [31:0] ready_o,
    output reg  [31:0] done_o
);
    // Users stay ready unless told to stall
    assign ready_o = ~busy_i;
    // One-cycle event; users finish one cycle later unless held back
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_o <= 32'h0000_0000;
            done_o  <= 32'h0000_0000;
        end else begin
            event_o <= fire_i;
            done_o  <= event_o & ~hold_i;
        end
    end
endmodule

//--- event_channel_flags_bench.sv
/* Self-checking bench of the event channel flag block with the channel-side model.
   Each access waits for waitrequest low; only the watchdog ends a hang. */
`timescale 1ns/1ns
module event_channel_flags_bench;
    logic        clock_i = 0, rst_n_i = 0, avs_read = 0, avs_write = 0;
    logic [10:0] avs_address = '0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, fire = '0, busy = '0, hold = '0, rdv;
    wire  [31:0] avs_readdata, ev, rdy, dn, chan_irq_o;
    wire         avs_waitrequest, irq_o;
    int          num_errors = 0, cmp_count = 0, ch;
    always #5 clock_i = ~clock_i;
    event_channel_flags event_channel_flags_i (.clock_i, .rst_n_i, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .chan_event_i(ev), .chan_users_ready_i(rdy), .chan_users_done_i(dn), .chan_irq_o, .irq_o);
    event_users_model event_users_model_i (.clock_i, .rst_n_i, .fire_i(fire), .busy_i(busy),
        .hold_i(hold), .event_o(ev), .ready_o(rdy), .done_o(dn));
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Held until waitrequest is seen low; a spare edge avoids a double drive
    task acc(input logic w, input logic [10:0] a, input logic [31:0] d);
        int t;
        t = 0;
        avs_read <= !w; avs_write <= w; avs_address <= a; avs_writedata <= d;
        @(posedge clock_i);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clock_i);
            t++;
        end
        rdv = avs_readdata;
        chk("wait_states", 1, t);
        avs_read <= 0; avs_write <= 0;
        @(posedge clock_i);
    endtask
    function [10:0] fa(input int c);
        return 11'h026 + 11'(8 * c);
    endfunction
    function [31:0] fexp(input logic e, o);
        return {30'h0, e, o};
    endfunction
    // Event on one channel, optionally with stalled or slow users
    task fire_ch(input int c, input logic b, h);
        fire <= 32'h1 << c; busy <= {31'h0, b} << c; hold <= {31'h0, h} << c;
        @(posedge clock_i);
        fire <= '0;
        repeat (3) @(posedge clock_i);
        busy <= '0; hold <= '0;
        @(posedge clock_i);
    endtask
    initial begin
        #200000;
        num_errors++;
        summarize;
    end
    initial begin
        void'($urandom(32970));
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1;
        @(posedge clock_i);
        for (ch = 0; ch < 32; ch++) begin
            acc(0, fa(ch), 0); chk("flag_reset", fexp(0, 0), rdv);
        end
        acc(1, 11'h135, $urandom); acc(0, 11'h135, 0); chk("unmapped", 0, rdv);
        $display("reset test done");
        repeat (8) begin
            ch = $urandom_range(30, 1);
            fire_ch(ch, 0, 0); acc(0, fa(ch), 0); chk("evd_set", fexp(1, 0), rdv);
            acc(1, fa(ch), $urandom & 32'hffff_fffc); acc(0, fa(ch), 0);
            chk("evd_keep", fexp(1, 0), rdv);
            acc(1, fa(ch), 32'h2); acc(0, fa(ch), 0); chk("evd_clr", fexp(0, 0), rdv);
        end
        $display("detect test done");
        fire_ch(31, 1, 0); acc(0, fa(31), 0); chk("ovr_busy", fexp(1, 1), rdv);
        acc(1, fa(31), 32'h1); acc(0, fa(31), 0); chk("ovr_clr", fexp(1, 0), rdv);
        acc(1, fa(31), 32'h2); fire_ch(31, 0, 1); fire_ch(31, 0, 0);
        acc(0, fa(31), 0); chk("ovr_pending", fexp(1, 1), rdv);
        acc(1, fa(31), 32'h3); acc(1, 11'h134, 32'h8000_0000); fire_ch(31, 1, 0);
        acc(0, fa(31), 0); chk("async", fexp(0, 0), rdv);
        // Event and overrun reach the slice at the edge where the clear lands
        fork
            acc(1, fa(5), 32'h3);
            begin
                fire <= 32'h20; busy <= 32'h20;
                @(posedge clock_i);
                fire <= '0;
                @(posedge clock_i);
                busy <= '0;
            end
        join
        acc(0, fa(5), 0); chk("set_wins", fexp(1, 1), rdv);
        $display("overrun test done");
        acc(1, 11'h132, 32'h1); acc(1, 11'h131, 32'h3); fire_ch(0, 0, 0);
        chk("irq_evd", 32'h1, chan_irq_o & 32'h1);
        chk("irq_on", 1, irq_o);
        acc(1, 11'h131, 0); chk("irq_masked", 0, irq_o);
        acc(1, 11'h131, 32'h3); acc(1, fa(0), 32'h2); chk("irq_evd_clr", 0, chan_irq_o);
        acc(1, 11'h130, 32'h3); chk("irq_cleared", 0, irq_o);
        acc(1, 11'h133, 32'h1); fire_ch(0, 1, 0); chk("irq_ovr", 32'h1, chan_irq_o);
        acc(0, 11'h130, 0); chk("irq_status", 32'h3, rdv);
        acc(1, fa(0), 32'h3); acc(1, 11'h130, 32'h3); chk("irq_end", 0, irq_o);
        $display("interrupt test done");
        summarize;
    end
endmodule
